// [rtl/symmetric_fir_dma_mac.sv]
`timescale 1ns/1ps
`include "fir_consts.svh"

// Summary of operation
// - Each output is the sum of coefficient i times the sample i steps back, i from 0 to taps-1.
// - All products and accumulation are signed, coefficient times sample.
// - Transfers and arithmetic for one output are watched against the table word 0 period; still running at its end raises deadline_miss.
// - Every single channel transfer takes exactly two clock cycles.
// - After setup the engine runs on its own channels, multiplier and memory.
// - Samples go into a circular store where each new one replaces the oldest without moving data.
// - The circular store is twice the maximum tap count deep.
// - The coefficient channel moves each coefficient into the first multiplier operand.
// - Per coefficient, the up-walking sample goes to operand two, then the down-walking one.
// - The up-walking channel increments its source address after every transfer.
// - The down-walking channel decrements its source address after every transfer.
// - The timer compare value gates all channels: zero disables, eleven triggers every 12 clocks.
module symmetric_fir_dma_mac #(
  parameter int DATA_W   = 16,
  parameter int MAX_TAPS = 256,
  parameter int ACC_W    = 2 * DATA_W + 8,
  parameter int TMR_W    = 16
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Parameter table load port
  input  wire logic              table_we,
  input  wire logic [15:0]       table_addr,
  input  wire logic [DATA_W-1:0] table_wdata,
  // Channel trigger gate
  input  wire logic [TMR_W-1:0]  sample_timer_compare,
  // Input samples
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [DATA_W-1:0] in_data,
  // Filter results
  output logic                   res_valid,
  input  wire logic              res_ready,
  output logic [ACC_W-1:0]       res_data,
  // Status
  output logic                   period_tick,
  output logic                   deadline_miss
);

  localparam int NCOEF  = (MAX_TAPS + 1) / 2;
  localparam int TDEPTH = `FIR_TABLE_COEF_BASE + NCOEF;
  localparam int TB_W   = $clog2(TDEPTH);
  localparam int SDEPTH = 2 * MAX_TAPS;
  localparam int SA_W   = $clog2(SDEPTH);

  // Parameter table and circular sample store
  logic [DATA_W-1:0] param_table [TDEPTH];
  logic [DATA_W-1:0] sample_buf  [SDEPTH];

  fir_pkg::engine_state_t state;
  logic                   phase;
  logic [SA_W-1:0]        taps;
  logic [SA_W-1:0]        half;
  logic [SA_W-1:0]        wr_pos;
  logic [SA_W-1:0]        up_addr;
  logic [SA_W-1:0]        down_addr;
  logic [SA_W-1:0]        coef_idx;
  logic [DATA_W-1:0]      xfer_data;
  logic [DATA_W-1:0]      signed_mac_operand_one;
  logic [DATA_W-1:0]      mult_operand_two;
  logic [ACC_W-1:0]       acc;
  logic [2*DATA_W-1:0]    product;
  logic [TMR_W-1:0]       tmr_cnt;
  logic                   trig;
  logic                   trig_pending;
  logic                   step_start;
  logic [DATA_W-1:0]      period_cnt;
  logic                   accept;
  logic                   last_pair;

  fifo_if #(.WIDTH(ACC_W)) res_if ();

  // Table word 1 carries the tap count, truncated to the store address width
  assign taps      = SA_W'(param_table[`FIR_TABLE_TAPS_IDX]);
  assign half      = SA_W'((taps + 1'b1) >> 1);
  assign in_ready  = (state == fir_pkg::ST_IDLE) && (taps != '0);
  assign accept    = in_valid && in_ready;
  assign last_pair = (coef_idx == half - 1'b1);
  assign step_start = (state == fir_pkg::ST_WAIT_TRIG) && trig_pending;

  // Signed product of operand one and the channel latch
  assign product = $signed(signed_mac_operand_one) * $signed(xfer_data);

  // Table writes from the processor during setup
  always_ff @(posedge sys_clk) begin
    if (table_we && (int'(table_addr) < TDEPTH)) begin
      param_table[TB_W'(table_addr)] <= table_wdata;
    end
  end

  // New sample written twice, so any window of taps words is linear in the store
  always_ff @(posedge sys_clk) begin
    if (accept) begin
      sample_buf[wr_pos]              <= in_data;
      sample_buf[SA_W'(wr_pos + taps)] <= in_data;
    end
  end

  // Write position walks modulo the tap count; oldest slot is reused
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pos <= '0;
    end else if (accept) begin
      wr_pos <= (wr_pos + 1'b1 >= taps) ? '0 : SA_W'(wr_pos + 1'b1);
    end
  end

  // Sampling timer: compare zero stops all channels, else fire every compare+1 clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_cnt <= '0;
      trig    <= 1'b0;
    end else if (sample_timer_compare == `FIR_TIMER_OFF) begin
      tmr_cnt <= '0;
      trig    <= 1'b0;
    end else if (tmr_cnt >= sample_timer_compare) begin
      tmr_cnt <= '0;
      trig    <= 1'b1;
    end else begin
      tmr_cnt <= tmr_cnt + 1'b1;
      trig    <= 1'b0;
    end
  end

  // One trigger releases one step; a zero compare drops a held trigger so every channel stops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_pending <= 1'b0;
    end else if (trig) begin
      trig_pending <= (sample_timer_compare != `FIR_TIMER_OFF);
    end else if (step_start || sample_timer_compare == `FIR_TIMER_OFF) begin
      trig_pending <= 1'b0;
    end
  end

  // Engine sequencer, no processor help once the table is loaded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fir_pkg::ST_IDLE;
      phase <= 1'b0;
    end else begin
      case (state)
        fir_pkg::ST_IDLE: begin
          if (accept) begin
            state <= fir_pkg::ST_WAIT_TRIG;
          end
        end
        fir_pkg::ST_WAIT_TRIG: begin
          if (trig_pending) begin
            state <= fir_pkg::ST_COEF;
          end
        end
        fir_pkg::ST_COEF: begin
          phase <= !phase;
          if (phase) begin
            state <= fir_pkg::ST_UP;
          end
        end
        fir_pkg::ST_UP: begin
          phase <= !phase;
          if (phase) begin
            state <= fir_pkg::ST_DOWN;
          end
        end
        fir_pkg::ST_DOWN: begin
          phase <= !phase;
          if (phase) begin
            state <= last_pair ? fir_pkg::ST_EMIT : fir_pkg::ST_WAIT_TRIG;
          end
        end
        fir_pkg::ST_EMIT: begin
          if (res_if.ready) begin
            state <= fir_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= fir_pkg::ST_IDLE;
          phase <= 1'b0;
        end
      endcase
    end
  end

  // First half of each transfer fetches the source word into the channel latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_data <= '0;
    end else if (!phase) begin
      case (state)
        fir_pkg::ST_COEF: xfer_data <= param_table[TB_W'(`FIR_TABLE_COEF_BASE + coef_idx)];
        fir_pkg::ST_UP:   xfer_data <= sample_buf[up_addr];
        fir_pkg::ST_DOWN: xfer_data <= sample_buf[down_addr];
        default:          xfer_data <= xfer_data;
      endcase
    end
  end

  // Channel addresses: up starts at the oldest sample, down at the newest
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_addr   <= '0;
      down_addr <= '0;
      coef_idx  <= '0;
    end else if (accept) begin
      up_addr   <= SA_W'(wr_pos + 1'b1);
      down_addr <= SA_W'(wr_pos + taps);
      coef_idx  <= '0;
    end else if (phase && state == fir_pkg::ST_UP) begin
      up_addr   <= up_addr + 1'b1;
    end else if (phase && state == fir_pkg::ST_DOWN) begin
      down_addr <= down_addr - 1'b1;
      coef_idx  <= coef_idx + 1'b1;
    end
  end

  // Operand registers; a halved middle coefficient meets the same sample twice
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      signed_mac_operand_one <= '0;
      mult_operand_two       <= '0;
    end else if (phase && state == fir_pkg::ST_COEF) begin
      signed_mac_operand_one <= xfer_data;
    end else if (phase && (state == fir_pkg::ST_UP || state == fir_pkg::ST_DOWN)) begin
      mult_operand_two       <= xfer_data;
    end
  end

  // Accumulator adds each signed product as operand two is written
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
    end else if (state == fir_pkg::ST_EMIT && res_if.ready) begin
      acc <= '0;
    end else if (phase && (state == fir_pkg::ST_UP || state == fir_pkg::ST_DOWN)) begin
      acc <= acc + ACC_W'($signed(product));
    end
  end

  // Period watch from table word 0; a period ending mid-computation is flagged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt    <= '0;
      period_tick   <= 1'b0;
      deadline_miss <= 1'b0;
    end else if (param_table[`FIR_TABLE_TIMER_IDX] == '0 ||
                 period_cnt >= param_table[`FIR_TABLE_TIMER_IDX]) begin
      period_cnt    <= '0;
      period_tick   <= (param_table[`FIR_TABLE_TIMER_IDX] != '0);
      deadline_miss <= (param_table[`FIR_TABLE_TIMER_IDX] != '0) &&
                       (state != fir_pkg::ST_IDLE);
    end else begin
      period_cnt    <= period_cnt + 1'b1;
      period_tick   <= 1'b0;
      deadline_miss <= 1'b0;
    end
  end

  // Result goes out through the buffer; a full buffer holds the engine in emit
  assign res_if.valid = (state == fir_pkg::ST_EMIT);
  assign res_if.data  = acc;

  result_fifo #(
    .WIDTH (ACC_W),
    .DEPTH (`FIR_FIFO_DEPTH)
  ) u_result_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .fill      (res_if),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  chk_coef_two_cycle: assert property (
    state == fir_pkg::ST_COEF && !phase |=> state == fir_pkg::ST_COEF && phase ##1
      state == fir_pkg::ST_UP && !phase)
    else $error("coefficient transfer not two cycles");

  chk_up_then_down: assert property (
    state == fir_pkg::ST_UP && !phase |-> ##2 state == fir_pkg::ST_DOWN && !phase)
    else $error("down sample did not follow up sample");

  chk_up_addr_inc: assert property (
    state == fir_pkg::ST_UP && phase |=> up_addr == $past(up_addr) + 1'b1)
    else $error("up channel address did not increment");

  chk_down_addr_dec: assert property (
    state == fir_pkg::ST_DOWN && phase |=> down_addr == $past(down_addr) - 1'b1)
    else $error("down channel address did not decrement");

  chk_coef_to_op: assert property (
    state == fir_pkg::ST_COEF && phase |=> signed_mac_operand_one == $past(xfer_data))
    else $error("coefficient not moved into operand one");

  chk_op_two_load: assert property (
    phase && (state == fir_pkg::ST_UP || state == fir_pkg::ST_DOWN) |=>
      mult_operand_two == $past(xfer_data))
    else $error("sample not moved into operand two");

  chk_timer_off: assert property (
    sample_timer_compare == `FIR_TIMER_OFF [*2] |-> !trig)
    else $error("trigger while timer disabled");

  chk_timer_12clk: assert property (
    trig && sample_timer_compare == `FIR_TIMER_12CLK ##1
      (sample_timer_compare == `FIR_TIMER_12CLK) [*8] ##1
      (sample_timer_compare == `FIR_TIMER_12CLK) [*3] |-> !trig ##1 trig)
    else $error("trigger spacing not 12 clocks");

  chk_acc_cleared: assert property (
    state == fir_pkg::ST_EMIT && res_if.ready |=> acc == '0 && state == fir_pkg::ST_IDLE)
    else $error("accumulator not cleared after emit");

  chk_sample_dup: assert property (
    accept |=> sample_buf[$past(wr_pos)] == sample_buf[SA_W'($past(wr_pos) + taps)])
    else $error("folded sample copies differ");

  chk_mac_signed: assert property (
    state == fir_pkg::ST_DOWN && phase |=> acc == $past(acc) + ACC_W'($signed($past(product))))
    else $error("signed accumulate wrong");

  cov_result_out:  cover property (res_if.valid && res_if.ready);
  cov_odd_taps:    cover property (taps[0] && state == fir_pkg::ST_EMIT);
  cov_backpress:   cover property (state == fir_pkg::ST_EMIT && !res_if.ready);
  cov_deadline:    cover property (deadline_miss);

endmodule : symmetric_fir_dma_mac

// [inc/fir_consts.svh]
`ifndef FIR_CONSTS_SVH
`define FIR_CONSTS_SVH

// Parameter table layout, in table words
`define FIR_TABLE_TIMER_IDX 32'h0000_0000
`define FIR_TABLE_TAPS_IDX  32'h0000_0001
`define FIR_TABLE_COEF_BASE 32'h0000_0002

// Sample timer compare values
`define FIR_TIMER_OFF       16'h0000
`define FIR_TIMER_12CLK     16'h000b

// Cycles taken by one memory transfer of a channel
`define FIR_XFER_CYCLES     2

// Result buffer depth in words
`define FIR_FIFO_DEPTH      16

`endif

// [inc/fir_pkg.sv]
package fir_pkg;

  // Engine sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_COEF,
    ST_UP,
    ST_DOWN,
    ST_EMIT
  } engine_state_t;

endpackage : fir_pkg

// [inc/fifo_if.sv]
`timescale 1ns/1ps

// Valid/ready word stream between the engine and the result buffer
interface fifo_if #(
  parameter int WIDTH = 40
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fifo_if

// [rtl/result_fifo.sv]
`timescale 1ns/1ps

module result_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Filling side
  fifo_if.snk                   fill,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty without a counter
  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign fill.ready = !full;
  assign push      = fill.valid && !full;
  assign out_valid = !empty;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Storage writes
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : result_fifo

// [verif/sample_host.sv]
`timescale 1ns/1ps

// Host side model: loads the parameter table and offers input samples
module sample_host (
  // Clock
  input  wire logic        sys_clk,
  // Parameter table load
  output logic             table_we,
  output logic [15:0]      table_addr,
  output logic [15:0]      table_wdata,
  // Sample offer
  output logic             in_valid,
  input  wire logic        in_ready,
  output logic [15:0]      in_data
);
  // Idle levels at time zero
  initial begin
    table_we    = 1'b0;
    table_addr  = 16'h0000;
    table_wdata = 16'h0000;
    in_valid    = 1'b0;
    in_data     = 16'h0000;
  end

  // One table word; released data is inverted so stale values never look valid
  task write_word(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    table_we    <= 1'b1;
    table_addr  <= a;
    table_wdata <= d;
    @(posedge sys_clk);
    table_we    <= 1'b0;
    table_wdata <= ~d;
  endtask : write_word

  // Period first, tap count next, then only the stored half of the coefficients
  task load_filter(input logic [15:0] period, input int taps, input logic [15:0] c[$]);
    write_word(16'h0000, period);
    write_word(16'h0001, 16'(taps));
    foreach (c[j]) write_word(16'(2 + j), c[j]);
  endtask : load_filter

  // Offer held until in_ready is seen high at an edge, or the limit runs out
  task send_sample(input logic [15:0] x, input int limit, output bit taken);
    taken = 1'b0;
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_data  <= x;
    for (int n = 0; n < limit && !taken; n++) begin
      @(negedge sys_clk);
      if (in_ready === 1'b1) taken = 1'b1;
      @(posedge sys_clk);
    end
    in_valid <= 1'b0;
    in_data  <= ~x;
  endtask : send_sample
endmodule : sample_host

// [verif/symmetric_fir_dma_mac_tb.sv]
`timescale 1ns/1ps

module symmetric_fir_dma_mac_tb;
  logic        sys_clk;
  logic        rst_n;
  logic [15:0] sample_timer_compare;
  logic        res_ready;
  logic        table_we;
  logic [15:0] table_addr;
  logic [15:0] table_wdata;
  logic        in_valid;
  logic        in_ready;
  logic [15:0] in_data;
  logic        res_valid;
  logic [39:0] res_data;
  logic        period_tick;
  logic        deadline_miss;
  int          failures;
  int          cmp_count;
  int          cycles;
  longint      hist[$];
  longint      h[$];
  logic [15:0] pattern[$] = {16'h7fff, 16'h8000, 16'h0123, 16'hfedc, 16'h0001};

  sample_host host (
    .sys_clk(sys_clk), .table_we(table_we), .table_addr(table_addr),
    .table_wdata(table_wdata), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data)
  );

  symmetric_fir_dma_mac DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .table_we(table_we), .table_addr(table_addr),
    .table_wdata(table_wdata), .sample_timer_compare(sample_timer_compare),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .period_tick(period_tick),
    .deadline_miss(deadline_miss)
  );

  // 40 MHz clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard, well above the roughly 1400 cycles the scenarios need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task check(input logic [39:0] seen, input logic [39:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Direct-form sum over the full symmetric coefficient set
  function automatic logic [39:0] fir_ref();
    longint acc;
    acc = 0;
    foreach (h[i]) acc += h[i] * hist[hist.size() - 1 - i];
    return 40'(acc);
  endfunction : fir_ref

  task push(input logic [15:0] x, output bit ok);
    host.send_sample(x, 200, ok);
    if (ok) hist.push_back(longint'($signed(x)));
  endtask : push

  // Consumer takes one result; ok low when none arrives within the limit
  task pull(input int limit, output logic [39:0] v, output bit ok);
    ok = 1'b0;
    v  = '0;
    @(posedge sys_clk);
    res_ready <= 1'b1;
    for (int n = 0; n < limit && !ok; n++) begin
      @(negedge sys_clk);
      if (res_valid === 1'b1) begin
        ok = 1'b1;
        v  = res_data;
      end
      @(posedge sys_clk);
    end
    res_ready <= 1'b0;
  endtask : pull

  // One sample through; two steps of one trigger period plus eight cycles each, plus emit
  task run_one(input logic [15:0] x);
    bit          ok;
    logic [39:0] exp;
    logic [39:0] v;
    push(x, ok);
    check(40'(ok), 40'h1, "sample taken");
    exp = fir_ref();
    pull(2 * (12 + 8) + 4, v, ok);
    check(40'(ok), 40'h1, "result latency");
    check(v, exp, "filter output");
  endtask : run_one

  // Loads a two-word half table, then flushes the unreset sample store with zeros
  task setup(input int taps, input logic [15:0] c0, input logic [15:0] c1);
    bit          ok;
    logic [39:0] v;
    host.load_filter(16'h0100, taps, {c0, c1});
    h = {longint'($signed(c0)), longint'($signed(c1))};
    if (taps == 4) h = {h[0], h[1], h[1], h[0]};
    else h = {h[0], 2 * h[1], h[0]};
    hist.delete();
    repeat (taps) begin
      push(16'h0000, ok);
      check(40'(ok), 40'h1, "flush sample taken");
      pull(100, v, ok);
      check(40'(ok), 40'h1, "flush result out");
    end
  endtask : setup

  // Even tap count, signed sample extremes against a negative coefficient
  task test_even();
    setup(4, 16'hf000, 16'h0300);
    foreach (pattern[k]) run_one(pattern[k]);
  endtask : test_even

  // Odd tap count with the middle coefficient stored halved
  task test_odd();
    setup(3, 16'h0400, 16'hfe00);
    foreach (pattern[k]) run_one(pattern[k]);
  endtask : test_odd

  // Compare value of zero holds the channels; eleven releases them
  task test_gate();
    bit          ok;
    logic [39:0] exp;
    logic [39:0] v;
    int          early;
    int          ticks;
    int          misses;
    early  = 0;
    ticks  = 0;
    misses = 0;
    sample_timer_compare <= 16'h0000;
    push(16'h0456, ok);
    check(40'(ok), 40'h1, "sample taken while stopped");
    exp = fir_ref();
    // A watch period of 0x100 plus one clocks holds one tick, late as the engine is held
    repeat (257) begin
      @(negedge sys_clk);
      if (res_valid !== 1'b0) early++;
      if (period_tick === 1'b1) ticks++;
      if (deadline_miss === 1'b1) misses++;
    end
    check(40'(early), 40'h0, "output while stopped");
    check(40'(ticks), 40'h1, "period ticks in one period");
    check(40'(misses), 40'h1, "missed deadline while stopped");
    @(posedge sys_clk);
    sample_timer_compare <= 16'h000b;
    pull(60, v, ok);
    check(40'(ok), 40'h1, "restart latency");
    check(v, exp, "output after restart");
  endtask : test_gate

  // Results pile up until the buffer and the engine refuse, then drain with gaps
  task test_fill();
    bit          ok;
    int          taken;
    logic [39:0] v;
    logic [39:0] exp_q[$];
    taken = 0;
    ok    = 1'b1;
    while (ok && taken < 20) begin
      push(16'(16'h0100 * taken - 16'h0800), ok);
      if (ok) begin
        taken++;
        exp_q.push_back(fir_ref());
      end
    end
    check(40'(taken), 40'd17, "accepted before refusal");
    foreach (exp_q[k]) begin
      pull(60, v, ok);
      check(v, exp_q[k], "drained output");
      repeat (3) @(posedge sys_clk);
    end
    @(negedge sys_clk);
    check(40'(res_valid), 40'h0, "buffer empty after drain");
  endtask : test_fill

  initial begin
    failures             = 0;
    cmp_count            = 0;
    cycles               = 0;
    rst_n                = 1'b0;
    res_ready            = 1'b0;
    sample_timer_compare = 16'h000b;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_even();
    test_odd();
    test_gate();
    test_fill();
    wrap_up();
  end
endmodule : symmetric_fir_dma_mac_tb
